/* src/wdrc_top.sv */
// watchdog, reset pin generation and overtemperature supervision
// Behaviour
// - phase status 00 off, 01 first, 10 second
// - status bit 3 shows forced normal
// - status bit 2 shows development mode
// - development mode reloads autonomous code on reset
// - window selected in standby acts as timeout
// - window only for code 100 in normal
// - window overflow or early trigger resets, cause kept
// - second half trigger restarts timer
// - timeout for 010, or 100 in standby
// - timeout trigger restarts timer any time
// - timeout overflow sets fail, second one resets
// - standby timeout overflow gives cyclic wake
// - autonomous timeout only normal or standby rxd low
// - autonomous wake forces rxd low, restarts watchdog
// - system reset drives low pulse on pin
// - external low on pin is reset source
// - cold start width follows length select
// - warm start uses shortest pulse
// - length select bits 5:4 choose width
// - listed events all enter reset mode
// - overtemp shuts down, leaves through reset
// - temperature warning sets status and event
// - valid control write triggers, applies at once
// - mode change in normal forces reset 10000
// - invalid codes abandon write, flag failure
`timescale 1ns/1ns
module wdrc_top
    import wdrc_pkg::*;
#(
    parameter int EXT_RST_MIN_CYC = 25      // least external low on the pin, in cycles
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    // register port
    input  wire wdrc_req_t    reg_req_i,
    output logic [7:0]        reg_rdata_o,
    output logic              reg_rvalid_o,
    // device state inputs
    input  wire wdrc_opmode_t op_mode_i,
    input  wire logic         in_off_mode_i,
    input  wire logic         power_on_i,
    input  wire logic         undervolt_i,
    input  wire logic         temp_shutdown_i,
    input  wire logic         temp_warn_i,
    input  wire logic         rxd_level_i,
    input  wire logic         wake_event_i,
    input  wire logic         spi_fail_enable_i,
    input  wire logic         wdf_clear_i,
    input  wire logic         otw_clear_i,
    // reset pin, open drain
    input  wire logic         reset_pin_n_i,
    output logic              reset_pin_n_o,
    output logic              reset_pin_n_oe_o,
    // status and events
    output logic              reset_mode_o,
    output logic              overtemp_mode_o,
    output logic              supply_off_o,
    output logic              rxd_force_low_o,
    output logic [4:0]        reset_cause_bits_o,
    output logic              watchdog_fail_event_o,
    output logic              spi_fail_event_o,
    output logic              cyclic_wake_o,
    output logic              overtemp_warn_status_o,
    output logic              overtemp_warn_event_o,
    output logic [1:0]        undervolt_threshold_select_o
);

    // reset sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_RESET = 3'b010,
        ST_OTEMP = 3'b100
    } wdrc_state_t;

    wdrc_state_t  state;              // sequencer state
    wdrc_state_t  next_state;         // sequencer next state
    logic [2:0]   watchdog_mode_code; // programmed watchdog mode
    logic [3:0]   nominal_period_select; // programmed period code
    logic [1:0]   reset_length_select;   // cold start pulse length
    logic         forced_normal_enable;  // watchdog fully disabled
    logic         devel_mode_enable;     // software development mode
    logic [11:0]  presc;              // cycles within a tick
    logic         tick;               // one-cycle time base tick
    logic [15:0]  wd_cnt;             // ticks since last restart
    logic [15:0]  rst_cnt;            // ticks since reset pulse start
    logic [15:0]  rst_width;          // width of current pulse
    logic [7:0]   ext_cnt;            // cycles of external low
    logic         wd_was_on;          // watchdog active last cycle
    logic         warn_prev;          // last warning comparator level
    wdrc_period_t per;                // decoded period
    wdrc_period_t new_per;            // decoded period of a write
    logic         win_mode;           // watchdog in window mode
    logic         to_mode;            // watchdog in timeout mode
    logic         rxd_low;            // effective receive level low
    logic         ctrl_wr;            // write to control register
    logic         ctrl_ok;            // write carries valid codes
    logic         trigger;            // valid control write
    logic         illegal;            // mode change in normal
    logic         first_half;         // timer in first half
    logic         overflow;           // timer reached period end
    logic         ext_low;            // external reset seen
    logic         rst_req;            // some reset source fired
    logic         rst_cold;           // that source is a cold start
    logic [4:0]   rst_code;           // that source's cause code
    logic [15:0]  cold_width;         // width chosen by length select

    // decode of control writes
    assign ctrl_wr = reg_req_i.wr && (reg_req_i.addr == ADDR_WD_CTRL);
    assign per     = wdrc_period(nominal_period_select);
    assign new_per = wdrc_period(reg_req_i.wdata[NWP_MSB:NWP_LSB]);
    assign ctrl_ok = new_per.valid &&
                     (reg_req_i.wdata[WMC_MSB:WMC_LSB] == WMC_AUTO ||
                      reg_req_i.wdata[WMC_MSB:WMC_LSB] == WMC_TIMEOUT ||
                      reg_req_i.wdata[WMC_MSB:WMC_LSB] == WMC_WINDOW);
    assign illegal = ctrl_wr && ctrl_ok && (op_mode_i == OPM_NORMAL) &&
                     (reg_req_i.wdata[WMC_MSB:WMC_LSB] != watchdog_mode_code);
    assign trigger = ctrl_wr && ctrl_ok && !illegal;

    // effective watchdog mode; nothing runs outside the run state
    always_comb begin
        win_mode = 1'b0;
        to_mode  = 1'b0;
        rxd_low  = !rxd_level_i || rxd_force_low_o;
        if (state == ST_RUN && !forced_normal_enable) begin
            case (watchdog_mode_code)
                WMC_WINDOW: begin
                    win_mode = (op_mode_i == OPM_NORMAL);
                    to_mode  = (op_mode_i == OPM_STANDBY);
                end
                WMC_TIMEOUT: to_mode = (op_mode_i == OPM_NORMAL) || (op_mode_i == OPM_STANDBY);
                WMC_AUTO: to_mode = !devel_mode_enable &&
                                    ((op_mode_i == OPM_NORMAL) || (op_mode_i == OPM_STANDBY && rxd_low));
                default: begin
                    win_mode = 1'b0;
                    to_mode  = 1'b0;
                end
            endcase
        end
    end

    assign first_half = wd_cnt < (per.ticks >> 1);
    assign overflow   = tick && (wd_cnt >= per.ticks - 16'h0001);

    // cold width from the length select field
    always_comb begin
        case (reset_length_select)
            2'h0:    cold_width = RST_T_LONG;
            2'h1:    cold_width = RST_T_MID;
            2'h2:    cold_width = RST_T_SHORT;
            default: cold_width = RST_T_MIN;
        endcase
    end

    // reset source collection, most severe first
    always_comb begin
        rst_req  = 1'b1;
        rst_cold = 1'b1;
        rst_code = RC_POWER_ON;
        if (power_on_i) begin
            rst_code = RC_POWER_ON;
        end else if (undervolt_i) begin
            rst_code = RC_UNDERVOLT;
        end else begin
            rst_cold = 1'b0;
            if (illegal) begin
                rst_code = RC_ILLEGAL;
            end else if (win_mode && trigger && first_half) begin
                rst_code = RC_WD_EARLY;
            end else if (win_mode && overflow) begin
                rst_code = RC_WD_OVF;
            end else if (to_mode && overflow && watchdog_fail_event_o) begin
                rst_code = RC_WD_FAIL;
            end else if (ext_low) begin
                rst_code = RC_EXTERNAL;
            end else begin
                rst_req = 1'b0;
            end
        end
    end

    // time base prescaler
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || presc == 12'(CYC_PER_TICK - 1)) begin
            presc <= 12'h000;
        end else begin
            presc <= presc + 12'h001;
        end
    end
    assign tick = (presc == 12'(CYC_PER_TICK - 1));

    // external low filter; only looked at while the pin is released
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || reset_pin_n_i || reset_pin_n_oe_o) begin
            ext_cnt <= 8'h00;
        end else if (!ext_low) begin
            ext_cnt <= ext_cnt + 8'h01;
        end
    end
    assign ext_low = (ext_cnt >= 8'(EXT_RST_MIN_CYC));

    // sequencer next state
    always_comb begin
        next_state = state;
        if (temp_shutdown_i && !in_off_mode_i) begin
            next_state = ST_OTEMP;
        end else begin
            case (state)
                ST_RUN:   if (rst_req) next_state = ST_RESET;
                ST_RESET: if (rst_cnt > rst_width && !undervolt_i) next_state = ST_RUN;
                ST_OTEMP: next_state = ST_RESET;
                default:  next_state = ST_RESET;
            endcase
        end
    end

    // sequencer state, pulse width and cause
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state              <= ST_RESET;
            rst_cnt            <= 16'h0000;
            rst_width          <= RST_T_LONG;
            reset_cause_bits_o <= RC_POWER_ON;
        end else begin
            state <= next_state;
            if (next_state == ST_RESET && state != ST_RESET) begin
                rst_cnt <= 16'h0000;
                if (state == ST_OTEMP || rst_cold) begin
                    rst_width <= cold_width;
                end else begin
                    rst_width <= RST_T_MIN;
                end
                if (state == ST_RUN) begin
                    reset_cause_bits_o <= rst_code;
                end else begin
                    reset_cause_bits_o <= RC_OVERTEMP;
                end
            end else if (state == ST_RESET) begin
                if (tick && rst_cnt != 16'hFFFF) rst_cnt <= rst_cnt + 16'h0001;
                // undervoltage while in reset turns it into a cold start
                if (undervolt_i) rst_width <= cold_width;
            end
        end
    end

    // pin and mode outputs, taken from the coming state
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            reset_pin_n_oe_o <= 1'b1;
            reset_mode_o     <= 1'b1;
            overtemp_mode_o  <= 1'b0;
            supply_off_o     <= 1'b0;
        end else begin
            reset_pin_n_oe_o <= (next_state != ST_RUN);
            reset_mode_o     <= (next_state == ST_RESET);
            overtemp_mode_o  <= (next_state == ST_OTEMP);
            supply_off_o     <= (next_state == ST_OTEMP);
        end
    end
    assign reset_pin_n_o = 1'b0;

    // watchdog control register, reloaded on every system reset
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            watchdog_mode_code    <= WMC_TIMEOUT;
            nominal_period_select <= NWP_128;
        end else if (state != ST_RESET && next_state == ST_RESET) begin
            watchdog_mode_code    <= devel_mode_enable ? WMC_AUTO : WMC_TIMEOUT;
            nominal_period_select <= NWP_128;
        end else if (trigger) begin
            watchdog_mode_code    <= reg_req_i.wdata[WMC_MSB:WMC_LSB];
            nominal_period_select <= reg_req_i.wdata[NWP_MSB:NWP_LSB];
        end
    end

    // start-up and configuration registers; kept across system resets
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            reset_length_select          <= RLC_RESET;
            undervolt_threshold_select_o <= UVT_RESET;
            forced_normal_enable         <= FNM_RESET;
            devel_mode_enable            <= SDM_RESET;
        end else if (reg_req_i.wr && reg_req_i.addr == ADDR_STARTUP) begin
            reset_length_select <= reg_req_i.wdata[RLC_MSB:RLC_LSB];
        end else if (reg_req_i.wr && reg_req_i.addr == ADDR_CFG) begin
            undervolt_threshold_select_o <= reg_req_i.wdata[UVT_MSB:UVT_LSB];
            forced_normal_enable         <= reg_req_i.wdata[FNM_BIT];
            devel_mode_enable            <= reg_req_i.wdata[SDM_BIT];
        end
    end

    // watchdog timer
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wd_cnt    <= 16'h0000;
            wd_was_on <= 1'b0;
        end else begin
            wd_was_on <= win_mode || to_mode;
            // restart on trigger, on switch-on and after each overflow
            // second half restarts
            if (!(win_mode || to_mode) || !wd_was_on || trigger || overflow) begin
                wd_cnt <= 16'h0000;
            end else if (tick) begin
                wd_cnt <= wd_cnt + 16'h0001;
            end
        end
    end

    // watchdog fail event and cyclic wake
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            watchdog_fail_event_o <= 1'b0;
            cyclic_wake_o         <= 1'b0;
        end else begin
            // first overflow captured; set wins over clear
            if (state == ST_RUN && to_mode && overflow && !watchdog_fail_event_o) begin
                watchdog_fail_event_o <= 1'b1;
            end else if (wdf_clear_i) begin
                watchdog_fail_event_o <= 1'b0;
            end
            cyclic_wake_o <= to_mode && overflow && (op_mode_i == OPM_STANDBY);
        end
    end

    // forced receive low after a wake in autonomous standby
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rxd_force_low_o <= 1'b0;
        end else if (op_mode_i != OPM_STANDBY || state != ST_RUN) begin
            rxd_force_low_o <= 1'b0;
        end else if (wake_event_i && watchdog_mode_code == WMC_AUTO && rxd_level_i) begin
            rxd_force_low_o <= 1'b1;
        end
    end

    // interface failure and temperature warning events
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            spi_fail_event_o       <= 1'b0;
            overtemp_warn_status_o <= 1'b0;
            overtemp_warn_event_o  <= 1'b0;
            warn_prev              <= 1'b0;
        end else begin
            spi_fail_event_o       <= ctrl_wr && !ctrl_ok && spi_fail_enable_i;
            warn_prev              <= temp_warn_i && !in_off_mode_i;
            overtemp_warn_status_o <= temp_warn_i && !in_off_mode_i;
            if (temp_warn_i && !in_off_mode_i && !warn_prev) begin
                overtemp_warn_event_o <= 1'b1;
            end else if (otw_clear_i) begin
                overtemp_warn_event_o <= 1'b0;
            end
        end
    end

    // register read path, one cycle after the request
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_req_i.rd;
            reg_rdata_o  <= 8'h00;
            if (reg_req_i.rd) begin
                case (reg_req_i.addr)
                    ADDR_WD_CTRL: reg_rdata_o <= {watchdog_mode_code, 1'b0, nominal_period_select};
                    ADDR_WD_STAT: reg_rdata_o <= {4'h0, forced_normal_enable, devel_mode_enable,
                                                  !(win_mode || to_mode) ? WDS_OFF :
                                                  first_half ? WDS_FIRST : WDS_SECOND};
                    ADDR_STARTUP: reg_rdata_o <= {2'h0, reset_length_select, 4'h0};
                    ADDR_CFG:     reg_rdata_o <= {2'h0, undervolt_threshold_select_o,
                                                  forced_normal_enable, devel_mode_enable, 2'h0};
                    default:      reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

endmodule

/* src/wdrc_pkg.sv */
// shared constants, types and lookups of the watchdog and reset control block
package wdrc_pkg;

    // clock and time base
    localparam int CLK_PERIOD_NS   = 40;                    // 25 MHz system clock
    localparam int TICK_NS         = 100000;                // 100 us time base tick
    localparam int CYC_PER_TICK    = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICKS_PER_MS    = 1000000 / TICK_NS;

    // least output reset pulse widths, in microseconds
    localparam int RST_W_LONG_US   = 20000;
    localparam int RST_W_MID_US    = 10000;
    localparam int RST_W_SHORT_US  = 3600;
    localparam int RST_W_MIN_US    = 1000;
    localparam logic [15:0] RST_T_LONG  = 16'((RST_W_LONG_US * 1000 + TICK_NS - 1) / TICK_NS);
    localparam logic [15:0] RST_T_MID   = 16'((RST_W_MID_US * 1000 + TICK_NS - 1) / TICK_NS);
    localparam logic [15:0] RST_T_SHORT = 16'((RST_W_SHORT_US * 1000 + TICK_NS - 1) / TICK_NS);
    localparam logic [15:0] RST_T_MIN   = 16'((RST_W_MIN_US * 1000 + TICK_NS - 1) / TICK_NS);

    // register addresses
    localparam logic [6:0] ADDR_WD_CTRL  = 7'h00;
    localparam logic [6:0] ADDR_WD_STAT  = 7'h05;
    localparam logic [6:0] ADDR_STARTUP  = 7'h73;
    localparam logic [6:0] ADDR_CFG      = 7'h74;

    // field positions
    localparam int WMC_MSB = 7;
    localparam int WMC_LSB = 5;
    localparam int NWP_MSB = 3;
    localparam int NWP_LSB = 0;
    localparam int RLC_MSB = 5;
    localparam int RLC_LSB = 4;
    localparam int UVT_MSB = 5;
    localparam int UVT_LSB = 4;
    localparam int FNM_BIT = 3;
    localparam int SDM_BIT = 2;

    // watchdog mode codes
    localparam logic [2:0] WMC_AUTO    = 3'h1;
    localparam logic [2:0] WMC_TIMEOUT = 3'h2;
    localparam logic [2:0] WMC_WINDOW  = 3'h4;

    // period codes
    localparam logic [3:0] NWP_8    = 4'h8;
    localparam logic [3:0] NWP_16   = 4'h1;
    localparam logic [3:0] NWP_32   = 4'h2;
    localparam logic [3:0] NWP_64   = 4'hB;
    localparam logic [3:0] NWP_128  = 4'h4;
    localparam logic [3:0] NWP_256  = 4'hD;
    localparam logic [3:0] NWP_1024 = 4'hE;
    localparam logic [3:0] NWP_4096 = 4'h7;

    // reset values
    localparam logic [1:0] RLC_RESET = 2'h0;
    localparam logic [1:0] UVT_RESET = 2'h0;
    localparam logic       FNM_RESET = 1'b1;
    localparam logic       SDM_RESET = 1'b0;

    // watchdog phase codes
    localparam logic [1:0] WDS_OFF   = 2'h0;
    localparam logic [1:0] WDS_FIRST = 2'h1;
    localparam logic [1:0] WDS_SECOND = 2'h2;

    // reset cause codes
    localparam logic [4:0] RC_POWER_ON = 5'h00;
    localparam logic [4:0] RC_OVERTEMP = 5'h01;
    localparam logic [4:0] RC_UNDERVOLT = 5'h02;
    localparam logic [4:0] RC_EXTERNAL = 5'h03;
    localparam logic [4:0] RC_WD_EARLY = 5'h04;
    localparam logic [4:0] RC_WD_OVF   = 5'h05;
    localparam logic [4:0] RC_WD_FAIL  = 5'h06;
    localparam logic [4:0] RC_ILLEGAL  = 5'h10;

    // operating mode of the device, from the mode controller
    typedef enum logic [1:0] {
        OPM_OTHER   = 2'h0,
        OPM_NORMAL  = 2'h1,
        OPM_STANDBY = 2'h2
    } wdrc_opmode_t;

    // register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } wdrc_req_t;

    // period lookup result
    typedef struct packed {
        logic        valid;
        logic [15:0] ticks;
    } wdrc_period_t;

    // period code to tick count, invalid codes flagged
    function automatic wdrc_period_t wdrc_period(input logic [3:0] code);
        wdrc_period_t p;
        p.valid = 1'b1;
        case (code)
            NWP_8:    p.ticks = 16'(8 * TICKS_PER_MS);
            NWP_16:   p.ticks = 16'(16 * TICKS_PER_MS);
            NWP_32:   p.ticks = 16'(32 * TICKS_PER_MS);
            NWP_64:   p.ticks = 16'(64 * TICKS_PER_MS);
            NWP_128:  p.ticks = 16'(128 * TICKS_PER_MS);
            NWP_256:  p.ticks = 16'(256 * TICKS_PER_MS);
            NWP_1024: p.ticks = 16'(1024 * TICKS_PER_MS);
            NWP_4096: p.ticks = 16'(4096 * TICKS_PER_MS);
            default: begin
                p.valid = 1'b0;
                p.ticks = 16'(128 * TICKS_PER_MS);
            end
        endcase
        return p;
    endfunction

endpackage

/* bench/wdrc_top_asserts.sv */
// port checker of the watchdog and reset control block, bound to its top
`timescale 1ns/1ns
module wdrc_chk
    import wdrc_pkg::*;
(
    // clock and reset
    input wire logic      clk_sys_i,
    input wire logic      sys_rst_i,
    // watched ports
    input wire wdrc_req_t reg_req_i,
    input wire logic      reg_rvalid_o,
    input wire logic      power_on_i,
    input wire logic      in_off_mode_i,
    input wire logic      temp_shutdown_i,
    input wire logic      temp_warn_i,
    input wire logic      spi_fail_enable_i,
    input wire logic      reset_pin_n_o,
    input wire logic      reset_pin_n_oe_o,
    input wire logic      reset_mode_o,
    input wire logic      overtemp_mode_o,
    input wire logic      supply_off_o,
    input wire logic      spi_fail_event_o,
    input wire logic      overtemp_warn_status_o,
    input wire logic      overtemp_warn_event_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // every read gets its answer on the next cycle
    a_rd_answer: assert property (reg_req_i.rd |=> reg_rvalid_o) else $error("read not answered");
    a_pin_drain: assert property (reset_pin_n_o == 1'b0) else $error("pin driven high");
    a_reset_pulls: assert property (reset_mode_o |-> reset_pin_n_oe_o) else $error("pin free in reset");
    a_otp_off: assert property (overtemp_mode_o |-> reset_pin_n_oe_o && supply_off_o) else $error("otp outputs");
    a_otp_entry: assert property (temp_shutdown_i && !in_off_mode_i |-> ##[1:3] overtemp_mode_o)
        else $error("shutdown ignored");
    a_warn_set: assert property (temp_warn_i && !in_off_mode_i |-> ##[1:3] overtemp_warn_status_o)
        else $error("warning ignored");
    a_warn_event: assert property ($rose(overtemp_warn_status_o) |-> overtemp_warn_event_o)
        else $error("warning event missing");
    a_bad_code: assert property (reg_req_i.wr && reg_req_i.addr == ADDR_WD_CTRL && spi_fail_enable_i
        && !(reg_req_i.wdata[7:5] inside {3'h1, 3'h2, 3'h4}) |=> spi_fail_event_o) else $error("no fail pulse");
    a_pon_reset: assert property (power_on_i |=> reset_mode_o) else $error("power on ignored");
    // main scenarios reached
    c_read: cover property (reg_rvalid_o);
    c_otp: cover property (overtemp_mode_o);
    c_warn: cover property ($rose(overtemp_warn_status_o));
endmodule
bind wdrc_top wdrc_chk u_chk (.clk_sys_i, .sys_rst_i, .reg_req_i, .reg_rvalid_o, .power_on_i, .in_off_mode_i,
    .temp_shutdown_i, .temp_warn_i, .spi_fail_enable_i, .reset_pin_n_o, .reset_pin_n_oe_o, .reset_mode_o,
    .overtemp_mode_o, .supply_off_o, .spi_fail_event_o, .overtemp_warn_status_o, .overtemp_warn_event_o);

/* bench/wdrc_mcu_model.sv */
// microcontroller side of the open-drain reset pin, with the board pull-up
`timescale 1ns/1ns
module wdrc_mcu_model (
    // drivers of the wire
    input  wire logic dev_oe_i,
    input  wire logic pull_i,
    // resolved level
    output logic      pin_n_o
);
    assign pin_n_o = !(dev_oe_i || pull_i);
endmodule

/* bench/test_watchdog_and_reset_control.sv */
// register level bench of the watchdog and reset control block
`timescale 1ns/1ns
module test_watchdog_and_reset_control
    import wdrc_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, pon = 1'b0, tsd = 1'b0, tw = 1'b0, otwc = 1'b0, pull = 1'b0, pin, oe;
    logic [7:0] rdata;
    logic rv, otm, spf, ows, owe, rmode, soff;
    logic [4:0] cause;
    logic sfe = 1'b1;
    wdrc_opmode_t opm = OPM_STANDBY;
    wdrc_req_t req = '0;
    int error_cnt = 0, checks = 0;
    initial forever #20 clk = ~clk;
    wdrc_mcu_model mcu (.dev_oe_i(oe), .pull_i(pull), .pin_n_o(pin));
    wdrc_top #(.EXT_RST_MIN_CYC(3)) dut (.clk_sys_i(clk), .sys_rst_i(rst), .reg_req_i(req), .reg_rdata_o(rdata),
        .reg_rvalid_o(rv), .op_mode_i(opm), .in_off_mode_i(1'b0), .power_on_i(pon), .undervolt_i(1'b0),
        .temp_shutdown_i(tsd), .temp_warn_i(tw), .rxd_level_i(1'b1), .wake_event_i(1'b0), .spi_fail_enable_i(sfe),
        .wdf_clear_i(1'b0), .otw_clear_i(otwc), .reset_pin_n_i(pin), .reset_pin_n_o(), .reset_pin_n_oe_o(oe),
        .reset_mode_o(rmode), .overtemp_mode_o(otm), .supply_off_o(soff), .rxd_force_low_o(),
        .reset_cause_bits_o(cause), .watchdog_fail_event_o(), .spi_fail_event_o(spf), .cyclic_wake_o(),
        .overtemp_warn_status_o(ows), .overtemp_warn_event_o(owe), .undervolt_threshold_select_o());
    // compare one value and count it
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one write strobe
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) req <= '0;
    endtask
    // read strobe, answer looked at in its single valid cycle
    task rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) req <= '0;
        @(negedge clk) chk({7'h00, rv}, 8'h01);
        chk(rdata, exp);
    endtask
    // the one place the run ends
    task final_report;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // hang guard, the sequence needs about 33000 cycles, most of them a cold pulse
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_WD_STAT, 8'h08);
        rd(ADDR_STARTUP, 8'h00);
        wr(ADDR_STARTUP, 8'h30);
        rd(ADDR_STARTUP, 8'h30);
        wr(ADDR_CFG, 8'h0C);
        rd(ADDR_WD_STAT, 8'h0C);
        wr(ADDR_CFG, 8'h04);
        rd(ADDR_WD_STAT, 8'h04);
        rd(7'h40, 8'h00);
        wr(ADDR_WD_CTRL, 8'h64);
        @(negedge clk) chk({7'h00, spf}, 8'h01);
        // bad period code with the failure event disabled stays silent
        @(posedge clk) sfe <= 1'b0;
        wr(ADDR_WD_CTRL, 8'h49);
        @(negedge clk) chk({7'h00, spf}, 8'h00);
        @(posedge clk) tw <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk) chk({6'h00, ows, owe}, 8'h03);
        @(posedge clk) tw <= 1'b0;
        otwc <= 1'b1;
        @(posedge clk) otwc <= 1'b0;
        tsd <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk) chk({5'h00, otm, soff, pin}, 8'h06);
        @(posedge clk) tsd <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk) chk({otm, rmode, 1'b0, cause}, {2'h1, 1'b0, RC_OVERTEMP});
        @(posedge clk) pon <= 1'b1;
        @(posedge clk) pon <= 1'b0;
        @(negedge clk) chk({7'h00, rmode}, 8'h01);
        // cold pulse after overtemp follows the shortest select set above
        repeat ((RST_T_MIN - 16'h0001) * CYC_PER_TICK) @(posedge clk);
        @(negedge clk) chk({6'h00, rmode, pin}, 8'h02);
        repeat (4 * CYC_PER_TICK) @(posedge clk);
        @(negedge clk) chk({6'h00, rmode, pin}, 8'h01);
        // development mode reloads the autonomous code, watchdog off
        rd(ADDR_WD_CTRL, {WMC_AUTO, 1'b0, NWP_128});
        rd(ADDR_WD_STAT, 8'h04);
        // window chosen in standby runs as timeout
        wr(ADDR_WD_CTRL, {WMC_WINDOW, 1'b0, NWP_128});
        rd(ADDR_WD_STAT, 8'h05);
        // in normal the same write lands in the first half
        @(posedge clk) opm <= OPM_NORMAL;
        wr(ADDR_WD_CTRL, {WMC_WINDOW, 1'b0, NWP_128});
        @(negedge clk) chk({rmode, 2'h0, cause}, {1'b1, 2'h0, RC_WD_EARLY});
        final_report();
    end
endmodule
